/* rtl/eudc_pkg.sv */
// Package: constants shared by the event up/down counter bank
package eudc_pkg;
  localparam int          EUDC_NUM_COUNTERS = 8;                 // Counter instances
  localparam int          EUDC_COUNT_W      = 32;                // Signed count width
  localparam int          EUDC_TIME_W       = 64;                // Date/time stamp width
  localparam int          EUDC_UNITS_W      = 48;                // Units label, six ASCII bytes
  localparam logic [31:0] EUDC_COUNT_MAX    = 32'h7FFF_FFFF;     // +2,147,483,647
  localparam logic [31:0] EUDC_COUNT_MIN    = 32'h8000_0000;     // -2,147,483,648
  localparam logic [31:0] EUDC_COUNT_RST    = 32'h0000_0000;     // Reset and clear value
  // Counter run state, one-hot
  typedef enum logic [1:0] {
    EUDC_ST_IDLE = 2'b01,                                        // Disabled, count held
    EUDC_ST_RUN  = 2'b10                                         // Enabled, counting
  } eudc_state_e;
endpackage : eudc_pkg

/* rtl/eudc_edge.sv */
// Rising-edge detector for a synchronous input
`timescale 1ns/1ps
`default_nettype none
module eudc_edge (
  input  wire logic clk_i,                                       // Core clock
  input  wire logic rst_ni,                                      // Synchronous reset, low
  input  wire logic ce_i,                                        // Clock enable
  input  wire logic sig_i,                                       // Sampled level
  output logic      rise_o                                       // High when sig rose
);
  logic prev_q;                                                  // Previous sample

  // Remember last sample; only a 0 to 1 change counts
  always_ff @(posedge clk_i) begin
    if (!rst_ni) begin
      prev_q <= 1'b0;
    end else if (ce_i) begin
      prev_q <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev_q;
endmodule // eudc_edge
`default_nettype wire

/* rtl/eudc_chan.sv */
// One signed up/down event counter with compare and capture
`timescale 1ns/1ps
`default_nettype none
module eudc_chan
  import eudc_pkg::*;
#(
  parameter int COUNT_W = EUDC_COUNT_W,                          // Count width
  parameter int TIME_W  = EUDC_TIME_W                            // Stamp width
) (
  input  wire logic               clk_i,                         // Core clock
  input  wire logic               rst_ni,                        // Synchronous reset, low
  input  wire logic               ce_i,                          // Clock enable
  input  wire logic               enable_i,                      // Counter enabled
  input  wire logic               up_i,                          // Increment level
  input  wire logic               down_i,                        // Decrement level
  input  wire logic               block_i,                       // Block counting
  input  wire logic               preset_select_input_i,         // Load-preset selector
  input  wire logic               reset_i,                       // Reset level
  input  wire logic               cap_clear_i,                   // Capture and clear level
  input  wire logic               cap_count_i,                   // Capture and continue level
  input  wire logic signed [COUNT_W-1:0] preset_i,               // Preset value
  input  wire logic signed [COUNT_W-1:0] compare_i,              // Setpoint
  input  wire logic [TIME_W-1:0]  now_i,                         // Current date/time
  input  wire logic               restore_i,                     // Restore saved counts
  input  wire logic signed [COUNT_W-1:0] nv_count_i,             // Saved running count
  input  wire logic signed [COUNT_W-1:0] nv_capture_i,           // Saved captured count
  output logic signed [COUNT_W-1:0] count_o,                     // Running count
  output logic signed [COUNT_W-1:0] capture_o,                   // Captured count
  output logic [TIME_W-1:0]       stamp_o,                       // Capture stamp
  output logic                    above_o,                       // Count above setpoint
  output logic                    equal_o,                       // Count equals setpoint
  output logic                    below_o                        // Count below setpoint
);
  eudc_state_e st_q;                                             // Run state
  logic signed [COUNT_W-1:0] cnt_q, cnt_d;                       // Running count
  logic signed [COUNT_W-1:0] cap_q;                              // Captured count
  logic [TIME_W-1:0]         stamp_q;                            // Capture stamp
  logic above_q, equal_q, below_q;                               // Compare flags
  logic up_r, dn_r, pre_r, rst_r, cc_r, ck_r;                    // Detected edges
  logic signed [COUNT_W-1:0] load_val;                           // Preset or zero

  // Commands act once per assertion, so they are edge detected too
  eudc_edge u_up (.clk_i(clk_i), .rst_ni(rst_ni), .ce_i(ce_i), .sig_i(up_i), .rise_o(up_r));
  eudc_edge u_dn (.clk_i(clk_i), .rst_ni(rst_ni), .ce_i(ce_i), .sig_i(down_i), .rise_o(dn_r));
  eudc_edge u_pr (.clk_i(clk_i), .rst_ni(rst_ni), .ce_i(ce_i),
                  .sig_i(preset_select_input_i), .rise_o(pre_r));
  eudc_edge u_rs (.clk_i(clk_i), .rst_ni(rst_ni), .ce_i(ce_i), .sig_i(reset_i), .rise_o(rst_r));
  eudc_edge u_cc (.clk_i(clk_i), .rst_ni(rst_ni), .ce_i(ce_i), .sig_i(cap_clear_i),
                  .rise_o(cc_r));
  eudc_edge u_ck (.clk_i(clk_i), .rst_ni(rst_ni), .ce_i(ce_i), .sig_i(cap_count_i),
                  .rise_o(ck_r));

  assign load_val = preset_select_input_i ? preset_i : COUNT_W'(EUDC_COUNT_RST);

  // Next count: loads beat counting edges; wraps come free from two's complement
  always_comb begin
    cnt_d = cnt_q;
    if (st_q == EUDC_ST_IDLE) begin
      if (enable_i) begin
        cnt_d = load_val;
      end
    end else if (cc_r) begin
      cnt_d = COUNT_W'(EUDC_COUNT_RST);
    end else if (rst_r) begin
      cnt_d = load_val;
    end else if (pre_r) begin
      cnt_d = preset_i;
    end else if (!block_i && (up_r ^ dn_r)) begin
      if (up_r) begin
        cnt_d = cnt_q + COUNT_W'(1);
      end else begin
        cnt_d = cnt_q - COUNT_W'(1);
      end
    end
  end

  // Run state and count register
  always_ff @(posedge clk_i) begin
    if (!rst_ni) begin
      st_q  <= EUDC_ST_IDLE;
      cnt_q <= COUNT_W'(EUDC_COUNT_RST);
    end else if (ce_i) begin
      if (restore_i) begin
        cnt_q <= nv_count_i;
      end else begin
        cnt_q <= cnt_d;
      end
      case (st_q)
        EUDC_ST_IDLE: st_q <= enable_i ? EUDC_ST_RUN : EUDC_ST_IDLE;
        EUDC_ST_RUN:  st_q <= enable_i ? EUDC_ST_RUN : EUDC_ST_IDLE;
        default:      st_q <= EUDC_ST_IDLE;
      endcase
    end
  end

  // Capture register with stamp; either capture kind copies the pre-clear count
  always_ff @(posedge clk_i) begin
    if (!rst_ni) begin
      cap_q   <= COUNT_W'(EUDC_COUNT_RST);
      stamp_q <= '0;
    end else if (ce_i) begin
      if (restore_i) begin
        cap_q <= nv_capture_i;
      end else if (st_q == EUDC_ST_RUN && (cc_r || ck_r)) begin
        cap_q   <= cnt_q;
        stamp_q <= now_i;
      end
    end
  end

  // Compare flags, forced inactive while blocked or disabled
  always_ff @(posedge clk_i) begin
    if (!rst_ni) begin
      above_q <= 1'b0;
      equal_q <= 1'b0;
      below_q <= 1'b0;
    end else if (ce_i) begin
      if (block_i || st_q != EUDC_ST_RUN) begin
        above_q <= 1'b0;
        equal_q <= 1'b0;
        below_q <= 1'b0;
      end else begin
        above_q <= cnt_q > compare_i;
        equal_q <= cnt_q == compare_i;
        below_q <= cnt_q < compare_i;
      end
    end
  end

  assign count_o   = cnt_q;
  assign capture_o = cap_q;
  assign stamp_o   = stamp_q;
  assign above_o   = above_q;
  assign equal_o   = equal_q;
  assign below_o   = below_q;
endmodule // eudc_chan
`default_nettype wire

/* rtl/eudc_top.sv */
// Bank of eight event up/down counters with status outputs
// Functional notes
// - Eight identical independent counters, separate settings
// - Count only on rising input edges
// - Up edge adds one, wraps max to min
// - Down edge subtracts one, wraps min to max
// - Compare count to setpoint: above, equal, below
// - Block halts counting, forces flags inactive
// - Preset value loadable before or during running
// - On enable load preset if selected, else zero
// - Selector rising loads preset; falling does nothing
// - Reset loads preset if selected, else zero
// - Capture-and-clear stores count, stamp, then zeroes
// - Capture-and-continue stores count, stamp, keeps counting
// - Count, capture and stamp readable as status
// - Counts saved across power loss, restorable
// - Units label reported alongside count
`timescale 1ns/1ps
`default_nettype none
module eudc_top
  import eudc_pkg::*;
#(
  parameter int N       = EUDC_NUM_COUNTERS,                     // Counters
  parameter int COUNT_W = EUDC_COUNT_W,                          // Count width
  parameter int TIME_W  = EUDC_TIME_W,                           // Stamp width
  parameter int UNITS_W = EUDC_UNITS_W                           // Label width
) (
  input  wire logic                   CORE_CLK_I,                // 10 MHz core clock
  input  wire logic                   RESETN_I,                  // Synchronous reset, low
  input  wire logic                   CE_I,                      // Clock enable
  input  wire logic [N-1:0]           ENABLE_I,                  // Per-counter enable
  input  wire logic [N-1:0]           UP_I,                      // Increment operands
  input  wire logic [N-1:0]           DOWN_I,                    // Decrement operands
  input  wire logic [N-1:0]           BLOCK_I,                   // Block operands
  input  wire logic [N-1:0]           PRESET_SELECT_INPUT_I,     // Preset selectors
  input  wire logic [N-1:0]           RESET_I,                   // Reset operands
  input  wire logic [N-1:0]           CAP_CLEAR_I,               // Capture and clear
  input  wire logic [N-1:0]           CAP_COUNT_I,               // Capture and continue
  input  wire logic [N*COUNT_W-1:0]   PRESET_I,                  // Preset per counter
  input  wire logic [N*COUNT_W-1:0]   COMPARE_I,                 // Setpoint per counter
  input  wire logic [N*UNITS_W-1:0]   UNITS_I,                   // Units label per counter
  input  wire logic [TIME_W-1:0]      NOW_I,                     // Current date/time
  input  wire logic                   RESTORE_I,                 // Load saved counts
  input  wire logic [N*COUNT_W-1:0]   NV_COUNT_I,                // Saved running counts
  input  wire logic [N*COUNT_W-1:0]   NV_CAPTURE_I,              // Saved captured counts
  output logic [N*COUNT_W-1:0]        COUNT_O,                   // Running counts
  output logic [N*COUNT_W-1:0]        CAPTURE_O,                 // Captured counts
  output logic [N*TIME_W-1:0]         STAMP_O,                   // Capture stamps
  output logic [N*UNITS_W-1:0]        UNITS_O,                   // Units labels
  output logic [N-1:0]                COUNT_ABOVE_SETPOINT_O,    // Above flags
  output logic [N-1:0]                COUNT_EQUALS_SETPOINT_O,   // Equal flags
  output logic [N-1:0]                COUNT_BELOW_SETPOINT_O     // Below flags
);
  logic [UNITS_W-1:0] units_q [N];                               // Registered labels

  // Each channel is independent; outputs of channels are already flops
  for (genvar g = 0; g < N; g++) begin : g_chan
    eudc_chan #(
      .COUNT_W (COUNT_W),
      .TIME_W  (TIME_W)
    ) u_chan (
      .clk_i                 (CORE_CLK_I),
      .rst_ni                (RESETN_I),
      .ce_i                  (CE_I),
      .enable_i              (ENABLE_I[g]),
      .up_i                  (UP_I[g]),
      .down_i                (DOWN_I[g]),
      .block_i               (BLOCK_I[g]),
      .preset_select_input_i (PRESET_SELECT_INPUT_I[g]),
      .reset_i               (RESET_I[g]),
      .cap_clear_i           (CAP_CLEAR_I[g]),
      .cap_count_i           (CAP_COUNT_I[g]),
      .preset_i              (PRESET_I[g*COUNT_W +: COUNT_W]),
      .compare_i             (COMPARE_I[g*COUNT_W +: COUNT_W]),
      .now_i                 (NOW_I),
      .restore_i             (RESTORE_I),
      .nv_count_i            (NV_COUNT_I[g*COUNT_W +: COUNT_W]),
      .nv_capture_i          (NV_CAPTURE_I[g*COUNT_W +: COUNT_W]),
      .count_o               (COUNT_O[g*COUNT_W +: COUNT_W]),
      .capture_o             (CAPTURE_O[g*COUNT_W +: COUNT_W]),
      .stamp_o               (STAMP_O[g*TIME_W +: TIME_W]),
      .above_o               (COUNT_ABOVE_SETPOINT_O[g]),
      .equal_o               (COUNT_EQUALS_SETPOINT_O[g]),
      .below_o               (COUNT_BELOW_SETPOINT_O[g])
    );

    // Units label registered so the status output is a flop
    always_ff @(posedge CORE_CLK_I) begin
      if (!RESETN_I) begin
        units_q[g] <= '0;
      end else if (CE_I) begin
        units_q[g] <= UNITS_I[g*UNITS_W +: UNITS_W];
      end
    end
    assign UNITS_O[g*UNITS_W +: UNITS_W] = units_q[g];
  end
endmodule // eudc_top
`default_nettype wire

/* sim/eudc_top_props.sv */
// Checker of counter lane 0 of the event counter bank
`timescale 1ns/1ps
`default_nettype none
module eudc_top_props
  import eudc_pkg::*;
#(
  parameter int N       = EUDC_NUM_COUNTERS,             // Counters
  parameter int COUNT_W = EUDC_COUNT_W,                  // Count width
  parameter int TIME_W  = EUDC_TIME_W                    // Stamp width
) (
  input wire logic                 CORE_CLK_I,           // Core clock
  input wire logic                 RESETN_I,             // Synchronous reset, low
  input wire logic                 CE_I,                 // Clock enable
  input wire logic [N-1:0]         ENABLE_I,             // Enables
  input wire logic [N-1:0]         UP_I,                 // Up operands
  input wire logic [N-1:0]         DOWN_I,               // Down operands
  input wire logic [N-1:0]         BLOCK_I,              // Block operands
  input wire logic [N-1:0]         PRESET_SELECT_INPUT_I,// Preset selectors
  input wire logic [N-1:0]         RESET_I,              // Reset operands
  input wire logic [N-1:0]         CAP_CLEAR_I,          // Capture and clear
  input wire logic [N-1:0]         CAP_COUNT_I,          // Capture and continue
  input wire logic [N*COUNT_W-1:0] PRESET_I,             // Presets
  input wire logic [N*COUNT_W-1:0] COMPARE_I,            // Setpoints
  input wire logic [TIME_W-1:0]    NOW_I,                // Date/time
  input wire logic                 RESTORE_I,            // Restore saved counts
  input wire logic [N*COUNT_W-1:0] COUNT_O,              // Counts
  input wire logic [N*COUNT_W-1:0] CAPTURE_O,            // Captures
  input wire logic [N*TIME_W-1:0]  STAMP_O,              // Stamps
  input wire logic [N-1:0]         COUNT_ABOVE_SETPOINT_O, // Above flags
  input wire logic [N-1:0]         COUNT_EQUALS_SETPOINT_O,// Equal flags
  input wire logic [N-1:0]         COUNT_BELOW_SETPOINT_O  // Below flags
);
  wire logic [31:0] c0 = COUNT_O[31:0];                  // Lane 0 count
  wire logic [31:0] p0 = PRESET_I[31:0];                 // Lane 0 preset
  wire logic [31:0] k0 = COMPARE_I[31:0];                // Lane 0 setpoint
  wire logic [2:0]  f0 = {COUNT_ABOVE_SETPOINT_O[0], COUNT_EQUALS_SETPOINT_O[0],
                          COUNT_BELOW_SETPOINT_O[0]};    // Lane 0 flags
  wire logic [31:0] a0 = CAPTURE_O[31:0];                // Lane 0 captured count
  wire logic [63:0] t0 = STAMP_O[63:0];                  // Lane 0 capture stamp
  wire logic        e0 = ENABLE_I[0];                    // Lane 0 enable
  wire logic        u0 = UP_I[0];                        // Lane 0 up operand
  wire logic        d0 = DOWN_I[0];                      // Lane 0 down operand
  wire logic        r0 = RESET_I[0];                     // Lane 0 reset operand
  wire logic        x0 = CAP_CLEAR_I[0];                 // Lane 0 capture and clear
  wire logic        y0 = CAP_COUNT_I[0];                 // Lane 0 capture and continue
  wire logic        s0 = PRESET_SELECT_INPUT_I[0];       // Lane 0 preset selector
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);
  // Lane 0 already running; the reset term keeps a fresh reset out of it
  sequence s_run;
    e0 && $past(e0) && CE_I && $past(CE_I) && $past(RESETN_I) && !RESTORE_I && !BLOCK_I[0];
  endsequence
  // No load of any kind in this cycle
  sequence s_noload;
    !$rose(r0) && !$rose(x0) && !$rose(s0);
  endsequence
  // A lone up edge, a lone down edge, or no net edge at all
  sequence s_up;
    s_run ##0 s_noload ##0 ($rose(u0) && !$rose(d0));
  endsequence
  sequence s_dn;
    s_run ##0 s_noload ##0 ($rose(d0) && !$rose(u0));
  endsequence
  sequence s_none;
    s_run ##0 s_noload ##0 ($rose(u0) == $rose(d0));
  endsequence
  // Flags shown now were computed last cycle by a lane already running then
  sequence s_settled;
    $past(e0) && $past(e0, 2) && $past(CE_I) && $past(CE_I, 2) && $past(RESETN_I)
      && $past(RESETN_I, 2) && !$past(BLOCK_I[0]);
  endsequence
  // Lane 0 is being enabled at this edge
  sequence s_enter;
    e0 && !$past(e0) && CE_I && $past(CE_I) && !RESTORE_I;
  endsequence
  AST_UP_WRAP: assert property (s_up |=> c0 == $past(c0) + 32'h0000_0001)
    else $error("up edge did not add one");
  AST_DOWN_WRAP: assert property (s_dn |=> c0 == $past(c0) - 32'h0000_0001)
    else $error("down edge did not subtract one");
  AST_EDGE_ONLY: assert property (s_none |=> $stable(c0))
    else $error("count moved without a single edge");
  AST_BLOCK_FLAGS: assert property ((BLOCK_I[0] && CE_I)[*2] |-> f0 == 3'b000)
    else $error("flags active while blocked");
  AST_FLAGS: assert property (s_settled |->
    f0 == {$signed($past(c0)) > $signed($past(k0)), $past(c0) == $past(k0),
    $signed($past(c0)) < $signed($past(k0))}) else $error("flags wrong");
  AST_CAP_CLEAR: assert property (s_run ##0 $rose(x0) |=> a0 == $past(c0)
    && t0 == $past(NOW_I) && c0 == 32'h0000_0000) else $error("capture and clear wrong");
  AST_CAP_COUNT: assert property (s_run ##0 ($rose(y0) && !$rose(x0))
    |=> a0 == $past(c0) && t0 == $past(NOW_I)) else $error("capture wrong");
  AST_RESET_LOAD: assert property (s_run ##0 ($rose(r0) && !$rose(x0))
    |=> c0 == ($past(s0) ? $past(p0) : 32'h0000_0000)) else $error("reset load");
  AST_SEL_LOAD: assert property (s_run ##0 ($rose(s0) && !$rose(r0) && !$rose(x0))
    |=> c0 == $past(p0)) else $error("selector rise did not load");
  AST_ENABLE_LOAD: assert property (s_enter |=>
    c0 == ($past(s0) ? $past(p0) : 32'h0000_0000)) else $error("enable load wrong");
endmodule // eudc_top_props
bind eudc_top eudc_top_props #(.N(N), .COUNT_W(COUNT_W), .TIME_W(TIME_W)) u_eudc_top_props (.*);
`default_nettype wire

/* sim/eudc_oper_net.sv */
// Model of the logic operand network feeding the counter operands
`timescale 1ns/1ps
`default_nettype none
module eudc_oper_net (
  input  wire logic        clk_i,                        // Core clock
  input  wire logic [39:0] req_i,                        // Requested operand levels
  output logic      [39:0] oper_o                        // Operand levels
);
  // Operands change half a cycle clear of the sampling edge
  always_ff @(negedge clk_i) begin
    oper_o <= req_i;
  end
endmodule // eudc_oper_net
`default_nettype wire

/* sim/eudc_top_bench.sv */
// Self-checking bench of the event counter bank
`timescale 1ns/1ps
`default_nettype none
module eudc_top_bench
  import eudc_pkg::*;
;
  logic         clk, rstn, ce, rest;                     // Clock and controls
  logic [7:0]   en, blk, ps, hi, eq, lo;                 // Lane levels and flags
  logic [39:0]  ops, opr;                                // Up, down, reset, clear, capture
  logic [255:0] pre, cmp, nvc, nvp, cnt, cap;            // Lane words
  logic [383:0] uni, uno;                                // Unit labels
  logic [511:0] stm;                                     // Stamps
  logic [63:0]  now;                                     // Date/time
  int           failures, compares;                      // Tallies
  eudc_oper_net u_eudc_oper_net (.clk_i(clk), .req_i(ops), .oper_o(opr));
  eudc_top u_eudc_top (.CORE_CLK_I(clk), .RESETN_I(rstn), .CE_I(ce), .ENABLE_I(en),
    .UP_I(opr[7:0]), .DOWN_I(opr[15:8]), .BLOCK_I(blk), .PRESET_SELECT_INPUT_I(ps),
    .RESET_I(opr[23:16]), .CAP_CLEAR_I(opr[31:24]), .CAP_COUNT_I(opr[39:32]), .PRESET_I(pre),
    .COMPARE_I(cmp), .UNITS_I(uni), .NOW_I(now), .RESTORE_I(rest), .NV_COUNT_I(nvc),
    .NV_CAPTURE_I(nvp), .COUNT_O(cnt), .CAPTURE_O(cap), .STAMP_O(stm), .UNITS_O(uno),
    .COUNT_ABOVE_SETPOINT_O(hi), .COUNT_EQUALS_SETPOINT_O(eq), .COUNT_BELOW_SETPOINT_O(lo));
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One-cycle pulse on kinds k of lanes m; returns once flags have settled
  task automatic hit(input logic [4:0] k, input logic [7:0] m);
    for (int b = 0; b < 5; b++) ops[b*8+:8] <= k[b] ? m : 8'h00;
    tick(1);
    ops <= 40'h0;
    tick(2);
  endtask
  task automatic complete_run;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // A hung run is cut short and counted as a mismatch
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    complete_run();
  end
  initial begin
    {rstn, rest, en, blk, ps, ops} = '0;
    ce = 1'b1;
    pre = {8{32'h7FFF_FFFF}};
    cmp = {8{32'h8000_0000}};
    uni = {8{48'h6B77_685F_6F70}};
    now = 64'h0000_0000_0000_1234;
    nvc = {8{32'h0000_0042}};
    nvp = {8{32'h0000_0024}};
    failures = 0;
    compares = 0;
    tick(5);
    rstn = 1'b1;
    tick(1);
    ps = 8'h01;
    en = 8'h21;
    tick(2);
    chk(cnt[31:0], 32'h7FFF_FFFF);
    hit(5'h01, 8'h01);
    chk(cnt[31:0], 32'h8000_0000);
    hit(5'h02, 8'h01);
    chk(cnt[31:0], 32'h7FFF_FFFF);
    chk({hi[0], eq[0], lo[0]}, 3'b100);
    hit(5'h03, 8'h01);
    chk(cnt[31:0], 32'h7FFF_FFFF);
    blk = 8'h01;
    hit(5'h01, 8'h01);
    chk(cnt[31:0], 32'h7FFF_FFFF);
    chk({hi[0], eq[0], lo[0]}, 3'b000);
    blk = 8'h00;
    ce = 1'b0;
    hit(5'h01, 8'h01);
    ce = 1'b1;
    chk(cnt[31:0], 32'h7FFF_FFFF);
    ps = 8'h00;
    pre[31:0] = 32'h0000_0005;
    tick(2);
    chk(cnt[31:0], 32'h7FFF_FFFF);
    ps = 8'h01;
    tick(2);
    chk(cnt[31:0], 32'h0000_0005);
    hit(5'h01, 8'h01);
    hit(5'h05, 8'h01);
    chk(cnt[31:0], 32'h0000_0005);
    ps = 8'h00;
    hit(5'h04, 8'h01);
    chk(cnt[31:0], 32'h0000_0000);
    hit(5'h01, 8'h01);
    en = 8'h20;
    tick(1);
    en = 8'h21;
    tick(2);
    chk(cnt[31:0], 32'h0000_0000);
    cmp[31:0] = 32'h0000_0000;
    tick(2);
    chk({hi[0], eq[0], lo[0]}, 3'b010);
    hit(5'h02, 8'h01);
    chk({hi[0], eq[0], lo[0]}, 3'b001);
    hit(5'h01, 8'h01);
    hit(5'h01, 8'h01);
    now = 64'h0000_0000_0000_5678;
    hit(5'h10, 8'h01);
    chk(cap[31:0], 32'h0000_0001);
    chk(stm[63:0], 64'h0000_0000_0000_5678);
    hit(5'h01, 8'h01);
    chk(cnt[31:0], 32'h0000_0002);
    hit(5'h08, 8'h01);
    chk(cap[31:0], 32'h0000_0002);
    chk(cnt[31:0], 32'h0000_0000);
    hit(5'h01, 8'h20);
    chk(cnt[191:160], 32'h0000_0001);
    chk(cnt[31:0], 32'h0000_0000);
    chk(uno[47:0], 48'h6B77_685F_6F70);
    rest = 1'b1;
    tick(1);
    rest = 1'b0;
    tick(1);
    chk(cnt[31:0], 32'h0000_0042);
    chk(cap[31:0], 32'h0000_0024);
    complete_run();
  end
endmodule // eudc_top_bench
`default_nettype wire
